// [logic/omc_pkg.sv]
// Package with the timing constants, states and port groups of the module control block.
package omc_pkg;
    // Clock rate, and the cycles a pin change needs beyond a count: three sync stages,
    // the filter, the output register and a change that lands just after an edge.
    localparam longint unsigned OMC_CLK_HZ          = 64'd100_000_000;
    localparam longint unsigned OMC_SYNC_LAT        = 64'd6;
    // Times as specified, each in its own unit.
    localparam longint unsigned OMC_T_OFF_US        = 64'd100;
    localparam longint unsigned OMC_T_ON_MS         = 64'd2;
    localparam longint unsigned OMC_T_2W_MS         = 64'd300;
    localparam longint unsigned OMC_T_START_MS      = 64'd300;
    localparam longint unsigned OMC_T_START_COOL_S  = 64'd90;
    localparam longint unsigned OMC_T_PL2_MS        = 64'd300;
    localparam longint unsigned OMC_T_FAULT_ON_US   = 64'd1000;
    localparam longint unsigned OMC_T_RESET_US      = 64'd10;
    localparam longint unsigned OMC_T_RS_FC_US      = 64'd500;
    localparam longint unsigned OMC_T_RS_MS         = 64'd10;
    localparam longint unsigned OMC_T_LOS_US        = 64'd100;
    // Least hold of the laser-off request that clears a fault, rounded up.
    localparam logic [10:0] OMC_HOLD_CYC =
        11'((OMC_T_RESET_US * OMC_CLK_HZ + 64'd999_999) / 64'd1_000_000);
    // Reset values of the stored fault and signal-lost outputs.
    localparam logic OMC_FAULT_RST = 1'b0;
    localparam logic OMC_LOS_RST   = 1'b1;

    // Life cycle of the transmitter.
    typedef enum logic [1:0] {
        OMC_ST_START,
        OMC_ST_RUN,
        OMC_ST_FAULT
    } omc_state_t;

    // Status pins seen by the host.
    typedef struct packed {
        logic       laser_enable;
        logic       tx_fault;
        logic       rx_los;
        logic       mgmt_ready;
        logic       operational;
        logic       power_level2;
        logic       rate_stable;
        logic [1:0] rate;
    } omc_status_t;

    // Three-stage pin synchronisers.
    typedef struct packed {
        logic [2:0] laser_off;
        logic [2:0] rate_sel_0;
        logic [2:0] rate_sel_1;
        logic [2:0] fault;
        logic [2:0] signal;
    } omc_sync_t;
endpackage

// [logic/omc_control.sv]
// Control and status pin logic of the optical module: laser gate, fault, loss, start-up, rate.
//
// Function
// R1 - Laser-off request rising turns optical output off within 100 us.
// R2 - Laser-off request falling turns output back on within 2 ms.
// R3 - Management interface is ready no later than 300 ms after power-on.
// R4 - Uncooled module fully operational within 300 ms after start or recovery.
// R5 - Cooled module fully operational within 90 s after start or recovery.
// R6 - Power level II enable write completes within 300 ms of stop bit.
// R7 - Power level II disable write drops to level I within 300 ms.
// R8 - Transmitter fault flag asserts within 1 ms, or 50 ms when cooled.
// R9 - Laser-off request held high at least 10 us clears the fault flag.
// R10 - Fibre Channel rate select change gives stable output within 500 us.
// R11 - Other rate select change gives stable output within 10 ms.
// R12 - Signal-lost flag asserts within 100 us of losing input light.
// R13 - Signal-lost flag clears within 100 us of valid light returning.
// R14 - High or open laser-off request keeps transmitter off; low runs normally.
// R15 - Host times each response window itself and flags a timeout; the host model here times only the laser shut-off.
`timescale 1ns/100ps
module omc_control
    import omc_pkg::*;
#(
    // Each count sits under its limit by the cycles that the pin path and outputs add.
    parameter logic [24:0] MGMT_CYC     = 25'(OMC_T_2W_MS * OMC_CLK_HZ / 64'd1000 - 64'd1),
    parameter logic [33:0] START_CYC    =
        34'(OMC_T_START_MS * OMC_CLK_HZ / 64'd1000 - OMC_SYNC_LAT),
    parameter logic [33:0] START_COOL_CYC = 34'(OMC_T_START_COOL_S * OMC_CLK_HZ - OMC_SYNC_LAT),
    parameter logic [19:0] RS_FC_CYC    =
        20'(OMC_T_RS_FC_US * OMC_CLK_HZ / 64'd1_000_000 - OMC_SYNC_LAT),
    parameter logic [19:0] RS_CYC       = 20'(OMC_T_RS_MS * OMC_CLK_HZ / 64'd1000 - OMC_SYNC_LAT)
) (
    input  wire logic       clock_in,
    input  wire logic       reset_n_in,
    input  wire logic       laser_off_in,
    input  wire logic       rate_sel_0_in,
    input  wire logic       rate_sel_1_in,
    input  wire logic       laser_fault_in,
    input  wire logic       signal_detect_in,
    input  wire logic       cooled_in,
    input  wire logic       fc_mode_in,
    input  wire logic       pl2_write_in,
    input  wire logic       pl2_value_in,
    output logic            laser_enable_out,
    output logic            tx_fault_out,
    output logic            rx_los_out,
    output logic            mgmt_ready_out,
    output logic            operational_out,
    output logic            power_level2_out,
    output logic            rate_stable_out,
    output logic [1:0]      rate_out
);

    // Whole state of the block.
    typedef struct packed {
        omc_sync_t   sync;
        logic        off_f;
        logic        fault_f;
        logic        sig_f;
        logic [1:0]  rate_f;
        logic        strap_done;
        logic        cooled;
        omc_state_t  state;
        logic [33:0] start_cnt;
        logic [24:0] mgmt_cnt;
        logic [10:0] hold_cnt;
        logic [19:0] rate_cnt;
        omc_status_t st;
    } omc_regs_t;

    omc_regs_t st_reg;
    omc_regs_t st_next;

    // Filters a synchronised pin: the level changes once stages two and three agree.
    function automatic logic omc_filter(input logic [2:0] s, input logic held);
        omc_filter = (s[1] == s[2]) ? s[2] : held;
    endfunction

    // Next-state logic.
    always_comb begin
        logic [33:0] start_lim;
        start_lim = START_CYC;
        st_next = st_reg;
        // Shift each pin into its synchroniser; stage one only feeds stage two.
        st_next.sync.laser_off  = {st_reg.sync.laser_off[1:0], laser_off_in};
        st_next.sync.rate_sel_0 = {st_reg.sync.rate_sel_0[1:0], rate_sel_0_in};
        st_next.sync.rate_sel_1 = {st_reg.sync.rate_sel_1[1:0], rate_sel_1_in};
        st_next.sync.fault      = {st_reg.sync.fault[1:0], laser_fault_in};
        st_next.sync.signal     = {st_reg.sync.signal[1:0], signal_detect_in};
        st_next.off_f      = omc_filter(st_reg.sync.laser_off, st_reg.off_f);
        st_next.fault_f    = omc_filter(st_reg.sync.fault, st_reg.fault_f);
        st_next.sig_f      = omc_filter(st_reg.sync.signal, st_reg.sig_f);
        st_next.rate_f[0]  = omc_filter(st_reg.sync.rate_sel_0, st_reg.rate_f[0]);
        st_next.rate_f[1]  = omc_filter(st_reg.sync.rate_sel_1, st_reg.rate_f[1]);

        // Catch the cooling strap once, one cycle after reset release.
        if (!st_reg.strap_done) begin
            st_next.strap_done = 1'b1;
            st_next.cooled     = cooled_in;
        end
        if (st_reg.cooled) begin
            start_lim = START_COOL_CYC; // R5
        end

        // Management interface readiness counts from power-on only.
        if (st_reg.mgmt_cnt != MGMT_CYC) begin
            st_next.mgmt_cnt = st_reg.mgmt_cnt + 25'h0000001;
        end
        st_next.st.mgmt_ready = (st_reg.mgmt_cnt == MGMT_CYC); // R3

        // Hold time of the laser-off request, saturating at the clear threshold.
        if (!st_reg.off_f) begin
            st_next.hold_cnt = 11'h000;
        end else if (st_reg.hold_cnt != OMC_HOLD_CYC) begin
            st_next.hold_cnt = st_reg.hold_cnt + 11'h001;
        end

        // Transmitter life cycle.
        case (st_reg.state)
            OMC_ST_START: begin
                if (st_reg.off_f) begin
                    st_next.start_cnt = 34'h000000000; // R4
                end else if (st_reg.start_cnt >= start_lim) begin
                    st_next.state = OMC_ST_RUN; // R4
                end else begin
                    st_next.start_cnt = st_reg.start_cnt + 34'h000000001;
                end
            end
            OMC_ST_RUN: begin
                if (st_reg.off_f) begin
                    st_next.state     = OMC_ST_START;
                    st_next.start_cnt = 34'h000000000;
                end
            end
            OMC_ST_FAULT: begin
                if (st_reg.hold_cnt == OMC_HOLD_CYC) begin
                    st_next.state     = OMC_ST_START; // R9
                    st_next.start_cnt = 34'h000000000;
                end
            end
            default: begin
                st_next.state = OMC_ST_START;
            end
        endcase
        // A laser fault wins over every other transition and latches.
        if (st_reg.fault_f) begin
            st_next.state = OMC_ST_FAULT; // R8
        end

        // Status pins, each registered.
        st_next.st.tx_fault     = (st_next.state == OMC_ST_FAULT); // R8
        st_next.st.laser_enable = !st_reg.off_f && (st_next.state != OMC_ST_FAULT); // R1 R2 R14
        st_next.st.operational  = (st_reg.state == OMC_ST_RUN) && !st_reg.off_f;
        st_next.st.rx_los       = !st_reg.sig_f; // R12 R13

        // Power level change over the management write takes effect at once.
        if (pl2_write_in) begin
            st_next.st.power_level2 = pl2_value_in; // R6 R7
        end

        // Rate select: output reports unstable for a settle count after a change.
        st_next.st.rate = st_reg.rate_f;
        if (st_reg.rate_f != st_reg.st.rate) begin
            st_next.rate_cnt       = fc_mode_in ? RS_FC_CYC : RS_CYC; // R10 R11
            st_next.st.rate_stable = 1'b0;
        end else if (st_reg.rate_cnt != 20'h00000) begin
            st_next.rate_cnt = st_reg.rate_cnt - 20'h00001;
        end else begin
            st_next.st.rate_stable = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_reg                 <= '0;
            st_reg.off_f           <= 1'b1;
            st_reg.sync.laser_off  <= 3'h7; // R14
            st_reg.state           <= OMC_ST_START;
            st_reg.st.tx_fault     <= OMC_FAULT_RST;
            st_reg.st.rx_los       <= OMC_LOS_RST;
            st_reg.st.rate_stable  <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the state register.
    assign laser_enable_out = st_reg.st.laser_enable;
    assign tx_fault_out     = st_reg.st.tx_fault;
    assign rx_los_out       = st_reg.st.rx_los;
    assign mgmt_ready_out   = st_reg.st.mgmt_ready;
    assign operational_out  = st_reg.st.operational;
    assign power_level2_out = st_reg.st.power_level2;
    assign rate_stable_out  = st_reg.st.rate_stable;
    assign rate_out         = st_reg.st.rate;

    // Checks on the pin behaviour.
    chk_laser_off_fast: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R1
        $rose(st_reg.off_f) |=> !laser_enable_out)
        else $error("Laser stayed on after the off request.");
    chk_laser_on_fast: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R2
        $fell(st_reg.off_f) && !st_reg.fault_f && st_reg.state != OMC_ST_FAULT
        |=> laser_enable_out)
        else $error("Laser did not return after the off request fell.");
    chk_fault_sets: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R8
        st_reg.fault_f |=> tx_fault_out && !laser_enable_out)
        else $error("Fault flag missing after a laser fault.");
    chk_fault_clears: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R9
        st_reg.state == OMC_ST_FAULT && st_reg.hold_cnt == OMC_HOLD_CYC && !st_reg.fault_f
        |=> ##1 !tx_fault_out)
        else $error("Fault flag not cleared by a long off request.");
    chk_fault_holds: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R9
        tx_fault_out && !st_reg.off_f && st_reg.hold_cnt != OMC_HOLD_CYC |=> tx_fault_out)
        else $error("Fault flag cleared without an off request.");
    chk_mgmt_ready: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R3
        $rose(mgmt_ready_out) |-> st_reg.mgmt_cnt == MGMT_CYC)
        else $error("Management ready at the wrong time.");
    chk_start_done: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R4
        $rose(operational_out) |-> $past(st_reg.start_cnt, 2) >= START_CYC)
        else $error("Operational before the start-up count.");
    chk_los_follow: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R12
        $changed(st_reg.sig_f) |=> rx_los_out == !$past(st_reg.sig_f))
        else $error("Signal-lost flag did not follow the input light.");
    chk_rate_settle: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R10
        $changed(rate_out) |-> !rate_stable_out)
        else $error("Rate output stable right after a change.");
    chk_pl2_write: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R6
        pl2_write_in |=> power_level2_out == $past(pl2_value_in))
        else $error("Power level write not applied.");

    cov_fault_recover: cover property (@(posedge clock_in) disable iff (!reset_n_in)
        $fell(tx_fault_out));
    cov_operational: cover property (@(posedge clock_in) disable iff (!reset_n_in)
        $rose(operational_out));
    cov_rate_change: cover property (@(posedge clock_in) disable iff (!reset_n_in)
        $rose(rate_stable_out));
endmodule

// [sim/omc_host.sv]
// Host controller model that drives the laser-off pin and times the shut-off response.
`timescale 1ns/100ps
module omc_host
    import omc_pkg::*;
#(
    parameter int LIMIT = int'(OMC_T_OFF_US * OMC_CLK_HZ / 64'd1_000_000)
) (
    input  wire logic clock_in,
    input  wire logic reset_n_in,
    input  wire logic off_req_in,
    input  wire logic laser_enable_in,
    output logic      laser_off_out,
    output logic      timeout_out
);
    int wait_reg;

    // The pin idles at its pull-up level until the host leaves reset.
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            laser_off_out <= 1'b1;
            wait_reg      <= 0;
            timeout_out   <= 1'b0;
        end else begin
            laser_off_out <= off_req_in;
            wait_reg      <= (laser_off_out && laser_enable_in) ? wait_reg + 1 : 0;
            if (wait_reg > LIMIT) begin
                timeout_out <= 1'b1;
            end
        end
    end
endmodule

// [sim/optical_module_control_status_test.sv]
// Self-checking testbench of the module control block; the laser-off pin is driven through a host model, the other pins directly.
`timescale 1ns/100ps
module optical_module_control_status_test
    import omc_pkg::*;
;
    localparam int EN = 8, FLT = 7, LOS = 6, RDY = 5, OPR = 4, STB = 2;
    logic        clock_in = 1'b0, reset_n_in = 1'b0, off_req = 1'b0, fault = 1'b0;
    logic        rs0 = 1'b0, rs1 = 1'b0, sig = 1'b1, cooled = 1'b0, fc = 1'b0;
    logic        pl2_wr = 1'b0, pl2_val = 1'b0, laser_off, timeout;
    omc_status_t st;
    int          fail_count = 0, comparisons = 0, waited;

    // Free-running 100 MHz clock.
    always #5 clock_in = ~clock_in;

    omc_host host (.clock_in(clock_in), .reset_n_in(reset_n_in), .off_req_in(off_req),
        .laser_enable_in(st.laser_enable), .laser_off_out(laser_off), .timeout_out(timeout));

    omc_control #(.MGMT_CYC(25'd50), .START_CYC(34'd80), .START_COOL_CYC(34'd200),
        .RS_FC_CYC(20'd20), .RS_CYC(20'd40)) dut (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .laser_off_in(laser_off),
        .rate_sel_0_in(rs0), .rate_sel_1_in(rs1), .laser_fault_in(fault),
        .signal_detect_in(sig), .cooled_in(cooled), .fc_mode_in(fc),
        .pl2_write_in(pl2_wr), .pl2_value_in(pl2_val), .laser_enable_out(st.laser_enable),
        .tx_fault_out(st.tx_fault), .rx_los_out(st.rx_los), .mgmt_ready_out(st.mgmt_ready),
        .operational_out(st.operational), .power_level2_out(st.power_level2),
        .rate_stable_out(st.rate_stable), .rate_out(st.rate));

    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    task automatic check_bit(input logic got, input logic exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    // Waits a bounded number of cycles for one status bit, then compares it.
    task automatic wait_bit(input int i, input logic v, input int n, input string msg);
        #1; // Look only once the edge's updates have settled.
        waited = 0;
        while (st[i] !== v && waited < n) begin
            tick(1);
            waited++;
        end
        check_bit(st[i], v, msg);
    endtask

    task automatic do_reset(input logic cool);
        @(posedge clock_in) begin
            reset_n_in <= 1'b0;
            cooled     <= cool;
        end
        tick(20);
        check_bit(st.rx_los & st.rate_stable, 1'b1, "reset flags");
        check_bit(st.laser_enable | st.tx_fault | st.operational, 1'b0, "reset outputs");
        @(posedge clock_in) reset_n_in <= 1'b1;
    endtask

    task automatic test_startup();
        wait_bit(RDY, 1'b1, 60, "mgmt ready");
        wait_bit(OPR, 1'b1, 100, "operational");
        check_bit(st.laser_enable, 1'b1, "laser on");
        check_bit(st.rx_los, 1'b0, "light present");
    endtask

    task automatic test_off();
        @(posedge clock_in) off_req <= 1'b1;
        wait_bit(EN, 1'b0, 6, "laser off");
        check_bit(st.operational, 1'b0, "off not operational");
        check_bit(timeout, 1'b0, "host timer");
        @(posedge clock_in) off_req <= 1'b0;
        wait_bit(EN, 1'b1, 8, "laser back");
        wait_bit(OPR, 1'b1, 100, "restart");
    endtask

    // A short hold must leave the fault latched; a long one clears it.
    task automatic test_fault();
        @(posedge clock_in) fault <= 1'b1;
        wait_bit(FLT, 1'b1, 6, "fault set");
        check_bit(st.laser_enable, 1'b0, "fault gate");
        @(posedge clock_in) begin
            fault   <= 1'b0;
            off_req <= 1'b1;
        end
        tick(500);
        @(posedge clock_in) off_req <= 1'b0;
        tick(20);
        check_bit(st.tx_fault, 1'b1, "short hold");
        @(posedge clock_in) off_req <= 1'b1;
        tick(1010);
        wait_bit(FLT, 1'b0, 10, "fault clear");
        @(posedge clock_in) off_req <= 1'b0;
        wait_bit(EN, 1'b1, 10, "laser after fault");
        wait_bit(OPR, 1'b1, 100, "recovery");
    endtask

    task automatic test_los();
        @(posedge clock_in) sig <= 1'b0;
        wait_bit(LOS, 1'b1, 6, "los set");
        @(posedge clock_in) sig <= 1'b1;
        wait_bit(LOS, 1'b0, 6, "los clear");
    endtask

    task automatic test_rate(input logic f, input logic [1:0] r, input int lim);
        @(posedge clock_in) begin
            fc         <= f;
            {rs1, rs0} <= r;
        end
        wait_bit(STB, 1'b0, 6, "rate busy");
        check_bit(st.rate === r, 1'b1, "rate value");
        wait_bit(STB, 1'b1, lim + 2, "rate stable");
        check_bit(waited >= lim - 2, 1'b1, "settle span");
    endtask

    task automatic test_pl2(input logic v);
        @(posedge clock_in) begin
            pl2_wr  <= 1'b1;
            pl2_val <= v;
        end
        @(posedge clock_in) pl2_wr <= 1'b0;
        tick(1);
        check_bit(st.power_level2, v, "power level");
    endtask

    task automatic finish_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The tests need about 2300 cycles; the watchdog allows over eight times that.
    initial begin
        #200_000;
        fail_count++;
        finish_test();
    end

    // Main sequence.
    initial begin
        do_reset(1'b0);
        test_startup();
        test_off();
        test_fault();
        test_los();
        test_rate(1'b1, 2'b01, 20);
        test_rate(1'b0, 2'b10, 40);
        test_rate(1'b0, 2'b11, 40);
        test_rate(1'b1, 2'b00, 20);
        test_pl2(1'b1);
        test_pl2(1'b0);
        do_reset(1'b1);
        tick(100);
        check_bit(st.operational, 1'b0, "cooled early");
        wait_bit(OPR, 1'b1, 150, "cooled ready");
        finish_test();
    end
endmodule
